// [verification/drca_ctrl_model.sv]
// Memory controller model that puts one command on the pins per call.
// Assumes callers wait for the previous call to return.
`timescale 1ns/100ps
`default_nettype none
module drca_ctrl_model
	import drca_pkg::*;
(
	input wire logic clk, // Command clock
	output drca_pkg::drca_pins_type pins // Command pins to the device
);
	// ------------------------------------------------------------
	// Command issue
	// ------------------------------------------------------------
	// Clock runs and enable stays high, so exits are always clean
	// No termination pin is driven here, so termination stays off through exit
	initial pins = {1'b1, 4'hf, 3'h0, 14'h0};
	// One clock per command then deselect keeps column commands two clocks apart
	task issue(input logic [3:0] cmd, input logic [2:0] ba, input logic [13:0] a);
		@(negedge clk);
		{pins.cs_b, pins.ras_b, pins.cas_b, pins.we_b} = cmd;
		pins.bank = ba;
		pins.addr = a;
		@(negedge clk);
		// Deselected lines flip so a stale address never passes for a held one
		pins.cs_b = 1'b1;
		pins.bank = ~ba;
		pins.addr = ~a;
	endtask
endmodule
`default_nettype wire

// [verification/drca_top_assertions.sv]
// Checker for the DDR2 refresh and column front end.
// Assumes it is bound to drca_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module drca_top_assertions
	import drca_pkg::*;
(
	input wire logic clk, // Command clock
	input wire logic rst_b, // Reset, active low
	input wire drca_pkg::drca_pins_type pins, // Command pins
	input wire drca_pkg::drca_mode_type mode, // Mode settings
	input wire logic self_refresh, // In self refresh
	input wire drca_pkg::drca_beat_type beat, // Column beat
	input wire logic refresh_go, // Refresh pulse
	input wire logic [drca_row_w-1:0] refresh_row, // Refresh row
	input wire logic banks_idle, // Banks idle
	input wire logic exit_busy, // Exit window
	input wire logic refresh_busy, // Refresh window
	input wire logic cmd_error // Refused command
);
	logic live, quiet, free, is_ref, is_rd, is_wr;
	assign live = pins.cke && !pins.cs_b;
	assign quiet = pins.cs_b || (pins.ras_b && pins.cas_b && pins.we_b);
	assign free = !exit_busy && !refresh_busy && !self_refresh;
	assign is_ref = live && !pins.ras_b && !pins.cas_b && pins.we_b;
	assign is_rd = live && pins.ras_b && !pins.cas_b && pins.we_b;
	assign is_wr = live && pins.ras_b && !pins.cas_b && !pins.we_b;
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_four;
		beat.valid [*4] ##1 !beat.valid;
	endsequence
	sequence s_window;
		refresh_busy && !banks_idle;
	endsequence
	property p_ref; is_ref && free |=> refresh_go && !banks_idle; endproperty
	a_ref: assert property (p_ref) else $error("refresh not taken");
	property p_row; refresh_go |-> refresh_row == $past(refresh_row) + 14'h1; endproperty
	a_row: assert property (p_row) else $error("refresh row not stepped");
	property p_rfc; refresh_go |-> s_window [*8] ##1 !refresh_busy && banks_idle; endproperty
	a_rfc: assert property (p_rfc) else $error("refresh window length wrong");
	property p_quiet; quiet |=> !refresh_go && !cmd_error; endproperty
	a_quiet: assert property (p_quiet) else $error("idle command had an effect");
	property p_err; (exit_busy || refresh_busy) && live && !quiet |=> cmd_error && !refresh_go;
	endproperty
	a_err: assert property (p_err) else $error("command in window not refused");
	property p_exit; self_refresh && pins.cke && pins.cs_b && !exit_busy && !refresh_busy
		|=> exit_busy [*8] ##1 exit_busy
		##1 !exit_busy; endproperty
	a_exit: assert property (p_exit) else $error("exit window length wrong");
	property p_rl; is_rd && free && mode.add_lat == 3'h0 && mode.cas_lat == 4'h3
		&& mode.burst_len == drca_bl4_code |-> ##5 s_four; endproperty
	a_rl: assert property (p_rl) else $error("read burst timing wrong");
	property p_wl; is_wr && free && mode.add_lat == 3'h2 && mode.cas_lat == 4'h3
		|-> ##5 !beat.valid ##1 beat.valid && beat.write; endproperty
	a_wl: assert property (p_wl) else $error("write latency wrong");
	property p_seg; beat.valid && $past(beat.valid) |-> beat.col[9:3] == $past(beat.col[9:3]);
	endproperty
	a_seg: assert property (p_seg) else $error("burst left its segment");
endmodule
bind drca_top drca_top_assertions i_chk (.clk(clk), .rst_b(rst_b), .pins(pins), .mode(mode),
	.self_refresh(self_refresh), .beat(beat), .refresh_go(refresh_go),
	.refresh_row(refresh_row), .banks_idle(banks_idle), .exit_busy(exit_busy),
	.refresh_busy(refresh_busy), .cmd_error(cmd_error));
`default_nettype wire

// [verification/drca_top_tb.sv]
// Testbench for drca_top: refresh, exit window, idle commands and bursts.
// Assumes the controller model and the bound checker are compiled with it.
`timescale 1ns/100ps
`default_nettype none
module drca_top_tb;
	import drca_pkg::*;
	logic clk, rst_b, self_refresh, refresh_go, banks_idle, exit_busy, refresh_busy, cmd_error;
	drca_pins_type pins;
	drca_mode_type mode;
	drca_beat_type beat;
	logic [drca_row_w-1:0] refresh_row;
	int err_total, samples_checked, beats, b0;
	localparam logic [3:0] c_ref = 4'h1, c_rd = 4'h5, c_wr = 4'h4, c_nop = 4'h7, c_des = 4'h8;
	drca_top i_drca_top (.clk(clk), .rst_b(rst_b), .pins(pins), .mode(mode),
		.self_refresh(self_refresh), .beat(beat), .refresh_go(refresh_go),
		.refresh_row(refresh_row), .banks_idle(banks_idle), .exit_busy(exit_busy),
		.refresh_busy(refresh_busy), .cmd_error(cmd_error));
	drca_ctrl_model i_drca_ctrl_model (.clk(clk), .pins(pins));
	always #12.5 clk = ~clk;
	always @(posedge clk) if (beat.valid === 1'b1) beats++;
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wrap_up;
		$display("mismatches %0d comparisons %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task burst(input logic wr, il, bl8, input logic [2:0] al, input logic [3:0] cl,
		input logic [9:0] col);
		logic [2:0] i;
		@(negedge clk);
		mode = {bl8 ? drca_bl8_code : drca_bl4_code, il, cl, al};
		i_drca_ctrl_model.issue(wr ? c_wr : c_rd, 3'h5, {4'h0, col});
		repeat (int'(al) + int'(cl) + 1 - int'(wr)) @(negedge clk);
		for (int k = 0; k < (bl8 ? 8 : 4); k++)
		begin
			i = k[2:0];
			chk({1'b0, beat.valid, beat.write, beat.bank, beat.col}, {2'b01, wr, 3'h5, col[9:3],
				il ? col[2:0] ^ i : {col[2] ^ i[2], col[1:0] + i[1:0]}});
			@(negedge clk);
		end
		chk({15'h0, beat.valid}, 16'h0000);
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		rst_b = 1'b0;
		self_refresh = 1'b0;
		mode = {drca_bl4_code, 1'b0, 4'h3, 3'h0};
		repeat (3) @(negedge clk);
		chk({10'h0, beat.valid, refresh_go, banks_idle, exit_busy, refresh_busy, cmd_error},
			16'h0008);
		chk({2'h0, refresh_row}, 16'h0000);
		rst_b = 1'b1;
		i_drca_ctrl_model.issue(c_ref, 3'h7, 14'h3fff);
		chk({refresh_go, banks_idle, refresh_row}, {2'b10, 14'h1});
		i_drca_ctrl_model.issue(c_ref, 3'h0, 14'h0);
		chk({cmd_error, refresh_go, refresh_row}, {2'b10, 14'h1});
		repeat (6) @(negedge clk);
		chk({14'h0, banks_idle, refresh_busy}, 16'h0002);
		i_drca_ctrl_model.issue(c_ref, 3'h2, 14'h0155);
		chk({1'b0, refresh_go, refresh_row}, {2'b01, 14'h2});
		b0 = beats;
		i_drca_ctrl_model.issue(c_nop, 3'h3, 14'h0400);
		chk({cmd_error, refresh_go, refresh_row}, {2'b00, 14'h2});
		i_drca_ctrl_model.issue(c_des, 3'h1, 14'h1234);
		chk({cmd_error, refresh_go, refresh_row}, {2'b00, 14'h2});
		repeat (10) @(negedge clk);
		self_refresh = 1'b1;
		@(negedge clk);
		self_refresh = 1'b0;
		chk({15'h0, exit_busy}, 16'h0001);
		i_drca_ctrl_model.issue(c_rd, 3'h0, 14'h0000);
		chk({15'h0, cmd_error}, 16'h0001);
		repeat (12) @(negedge clk);
		chk({14'h0, exit_busy, cmd_error}, 16'h0000);
		chk(16'(beats - b0), 16'h0000);
		// Extra refresh after the exit window, as any re-entry would need
		i_drca_ctrl_model.issue(c_ref, 3'h4, 14'h2aaa);
		chk({1'b0, refresh_go, refresh_row}, {2'b01, 14'h3});
		repeat (8) @(negedge clk);
		burst(1'b0, 1'b0, 1'b0, 3'h0, 4'h3, 10'h001);
		burst(1'b0, 1'b1, 1'b1, 3'h2, 4'h3, 10'h2c5);
		burst(1'b1, 1'b0, 1'b1, 3'h2, 4'h3, 10'h3fb);
		burst(1'b1, 1'b1, 1'b0, 3'h6, 4'h2, 10'h10e);
		wrap_up;
	end
	initial
	begin
		err_total = 0;
		samples_checked = 0;
		beats = 0;
		repeat (3000) @(posedge clk);
		err_total++;
		wrap_up;
	end
endmodule
`default_nettype wire

// [verilog/drca_delay.sv]
// Shift line that posts a column command by a variable number of clocks.
// Assumes one command enters per clock at most.
`timescale 1ns/100ps
`default_nettype none
module drca_delay
	import drca_pkg::*;
#(
	parameter int depth = 16
)
(
	input wire logic clk, // Command clock
	input wire logic rst_b, // Asynchronous reset, active low
	input wire logic in_valid, // Command enters
	input wire logic [drca_bank_w+drca_col_w:0] in_data, // Write flag, bank, column
	input wire logic [3:0] sel, // Delay in clocks, 1 to depth
	output logic out_valid, // Command leaves
	output logic [drca_bank_w+drca_col_w:0] out_data // Delayed payload
);
	logic [depth-1:0] vld;
	logic [depth-1:0] next_vld;
	logic [drca_bank_w+drca_col_w:0] dat [depth];
	logic [drca_bank_w+drca_col_w:0] next_dat [depth];
	always_comb
	begin
		next_vld = {vld[depth-2:0], in_valid};
		next_dat[0] = in_data;
		for (int i = 1; i < depth; i++)
		begin
			next_dat[i] = dat[i-1];
		end
	end
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			vld <= '0;
			for (int i = 0; i < depth; i++)
			begin
				dat[i] <= '0;
			end
		end
		else
		begin
			vld <= next_vld;
			dat <= next_dat;
		end
	end
	assign out_valid = vld[sel - drca_one];
	assign out_data = dat[sel - drca_one];
endmodule
`default_nettype wire

// [verilog/drca_pkg.sv]
// Package for the DDR2 refresh and column access block.
// Shared command encodings, field layouts, limits and timing counts.
package drca_pkg;
	localparam int drca_clk_mhz = 40;
	localparam int drca_col_w = 10;
	localparam int drca_row_w = 14;
	localparam int drca_bank_w = 3;
	localparam logic [2:0] drca_bl4_code = 3'h2;
	localparam logic [2:0] drca_bl8_code = 3'h3;
	localparam logic [2:0] drca_al_max = 3'h6;
	localparam logic [3:0] drca_cl_min = 4'h2;
	localparam logic [3:0] drca_beats_bl4 = 4'h4;
	localparam logic [3:0] drca_beats_bl8 = 4'h8;
	localparam logic [3:0] drca_tccd_clk = 4'h2;
	localparam logic [3:0] drca_one = 4'h1;
	// Refresh cycle and self refresh exit times, ns; counts derived from the clock
	localparam int drca_trfc_ns = 195;
	localparam int drca_txsnr_ns = 205;
	localparam int drca_trfc_cyc = (drca_trfc_ns * drca_clk_mhz + 999) / 1000;
	localparam int drca_txsnr_cyc = (drca_txsnr_ns * drca_clk_mhz + 999) / 1000;
	localparam int drca_cnt_w = 8;
	localparam logic [drca_cnt_w-1:0] drca_trfc_load = drca_trfc_cyc[drca_cnt_w-1:0];
	localparam logic [drca_cnt_w-1:0] drca_txsnr_load = drca_txsnr_cyc[drca_cnt_w-1:0];
	localparam logic [drca_cnt_w-1:0] drca_cnt_zero = 8'h00;
	localparam logic [drca_cnt_w-1:0] drca_cnt_one = 8'h01;
	// Decoded commands
	typedef enum logic [3:0] {
		drca_cmd_nop = 4'h0,
		drca_cmd_ref = 4'h1,
		drca_cmd_rd = 4'h2,
		drca_cmd_wr = 4'h3,
		drca_cmd_other = 4'h4
	} drca_cmd_type;
	// Command pins of one edge
	typedef struct packed {
		logic cke;
		logic cs_b;
		logic ras_b;
		logic cas_b;
		logic we_b;
		logic [drca_bank_w-1:0] bank;
		logic [drca_row_w-1:0] addr;
	} drca_pins_type;
	// Mode settings
	typedef struct packed {
		logic [2:0] burst_len;
		logic interleave;
		logic [3:0] cas_lat;
		logic [2:0] add_lat;
	} drca_mode_type;
	// Column beat reaching the array
	typedef struct packed {
		logic valid;
		logic write;
		logic [drca_bank_w-1:0] bank;
		logic [drca_col_w-1:0] col;
	} drca_beat_type;
endpackage

// [verilog/drca_top.sv]
// DDR2 device command front end: refresh, self refresh exit and column bursts.
// Assumes command pins synchronous to clk and mode settings held steady.
// Functional notes
// - Refresh decode; one refresh per command
// - Refresh rows generated internally, inputs ignored
// - All banks idle after refresh
// - NOP does nothing, like deselect
// - Deselect ignores command and address
// - Burst stays inside its page segment
// - Posted column command held for AL plus one clock
// - Read latency equals AL plus CL plus two
// - Write latency equals read latency minus one
// - Additive latency zero through six supported
// - Burst length and order from mode
`timescale 1ns/100ps
`default_nettype none
module drca_top
	import drca_pkg::*;
(
	input wire logic clk, // Command clock
	input wire logic rst_b, // Asynchronous reset, active low
	input wire drca_pkg::drca_pins_type pins, // Command pins of this edge
	input wire drca_pkg::drca_mode_type mode, // Mode settings
	input wire logic self_refresh, // Device is in self refresh
	output drca_pkg::drca_beat_type beat, // Column beat to the array
	output logic refresh_go, // One refresh of the next row
	output logic [drca_row_w-1:0] refresh_row, // Row being refreshed
	output logic banks_idle, // All banks precharged after refresh
	output logic exit_busy, // Inside tXSNR after exit
	output logic refresh_busy, // Inside tRFC
	output logic cmd_error // Command broke an exit or refresh window
);
	import drca_pkg::*;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	drca_cmd_type cmd;
	logic exit_seen;
	always_comb
	begin
		cmd = drca_cmd_other;
		if (!pins.cke || pins.cs_b)
			cmd = drca_cmd_nop;
		else
		begin
			case ({pins.ras_b, pins.cas_b, pins.we_b})
				3'h7: cmd = drca_cmd_nop;
				3'h1: cmd = drca_cmd_ref;
				3'h5: cmd = drca_cmd_rd;
				3'h4: cmd = drca_cmd_wr;
				default: cmd = drca_cmd_other;
			endcase
		end
		// Exit: CKE high with deselect or NOP shape
		exit_seen = self_refresh && pins.cke &&
			(pins.cs_b || (pins.ras_b && pins.cas_b && pins.we_b));
	end

	// ----------------------------------------
	// Refresh and exit windows
	// ----------------------------------------
	typedef enum logic [2:0] {
		drca_st_idle = 3'h1,
		drca_st_exit = 3'h2,
		drca_st_refresh = 3'h4
	} drca_state_type;
	drca_state_type state;
	drca_state_type next_state;
	logic [drca_cnt_w-1:0] count;
	logic [drca_cnt_w-1:0] next_count;
	logic [drca_row_w-1:0] next_refresh_row;
	logic next_refresh_go;
	logic next_banks_idle;
	logic next_cmd_error;
	logic col_ok;
	always_comb
	begin
		next_state = state;
		next_count = (count == drca_cnt_zero) ? count : count - drca_cnt_one;
		next_refresh_row = refresh_row;
		next_refresh_go = 1'b0;
		next_banks_idle = banks_idle;
		next_cmd_error = 1'b0;
		col_ok = 1'b0;
		case (state)
			drca_st_idle:
			begin
				if (exit_seen)
				begin
					next_state = drca_st_exit;
					next_count = drca_txsnr_load;
				end
				else if (cmd == drca_cmd_ref && !self_refresh)
				begin
					// Row comes from the internal counter, never from the pins
					next_refresh_go = 1'b1;
					next_refresh_row = refresh_row + 1'b1;
					next_banks_idle = 1'b0;
					next_state = drca_st_refresh;
					next_count = drca_trfc_load;
				end
				else
					col_ok = !self_refresh;
			end
			drca_st_exit:
			begin
				if (cmd != drca_cmd_nop)
					next_cmd_error = 1'b1;
				if (count == drca_cnt_one)
					next_state = drca_st_idle;
			end
			drca_st_refresh:
			begin
				// Anything but NOP inside tRFC is flagged and dropped
				if (cmd != drca_cmd_nop)
					next_cmd_error = 1'b1;
				if (count == drca_cnt_one)
				begin
					next_state = drca_st_idle;
					next_banks_idle = 1'b1;
				end
			end
			default:
				next_state = drca_st_idle;
		endcase
	end
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= drca_st_idle;
			count <= drca_cnt_zero;
			refresh_row <= '0;
			refresh_go <= 1'b0;
			banks_idle <= 1'b1;
			cmd_error <= 1'b0;
			exit_busy <= 1'b0;
			refresh_busy <= 1'b0;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
			refresh_row <= next_refresh_row;
			refresh_go <= next_refresh_go;
			banks_idle <= next_banks_idle;
			cmd_error <= next_cmd_error;
			exit_busy <= (next_state == drca_st_exit);
			refresh_busy <= (next_state == drca_st_refresh);
		end
	end

	// ----------------------------------------
	// Posted column command
	// ----------------------------------------
	logic col_in;
	logic [3:0] post_sel;
	logic post_valid;
	logic [drca_bank_w+drca_col_w:0] post_data;
	// AL above six is clipped; a zero AL still costs the one clock of the line
	always_comb
	begin
		col_in = col_ok && (cmd == drca_cmd_rd || cmd == drca_cmd_wr);
		post_sel = {1'b0, (mode.add_lat > drca_al_max) ? drca_al_max : mode.add_lat} + drca_one;
	end
	drca_delay #(
		.depth(16)
	) u_post (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(col_in),
		.in_data({cmd == drca_cmd_wr, pins.bank, pins.addr[drca_col_w-1:0]}),
		.sel(post_sel),
		.out_valid(post_valid),
		.out_data(post_data)
	);

	// ----------------------------------------
	// Latency: read CL after the post line, write one less
	// ----------------------------------------
	// Separate lines so each command leaves at its own tap; tCCD keeps exits apart
	logic [3:0] rd_sel, wr_sel;
	logic rd_in, wr_in, rd_valid, wr_valid;
	logic [drca_bank_w+drca_col_w:0] rd_data, wr_data;
	logic lat_valid;
	logic [drca_bank_w+drca_col_w:0] lat_data;
	always_comb
	begin
		rd_sel = (mode.cas_lat < drca_cl_min) ? drca_cl_min : mode.cas_lat;
		wr_sel = rd_sel - drca_one;
		wr_in = post_valid && post_data[drca_bank_w+drca_col_w];
		rd_in = post_valid && !post_data[drca_bank_w+drca_col_w];
		lat_valid = rd_valid || wr_valid;
		lat_data = wr_valid ? wr_data : rd_data;
	end
	drca_delay #(.depth(16)) u_lat_rd (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(rd_in),
		.in_data(post_data),
		.sel(rd_sel),
		.out_valid(rd_valid),
		.out_data(rd_data)
	);
	drca_delay #(.depth(16)) u_lat_wr (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(wr_in),
		.in_data(post_data),
		.sel(wr_sel),
		.out_valid(wr_valid),
		.out_data(wr_data)
	);

	// ----------------------------------------
	// Burst sequencer
	// ----------------------------------------
	logic [3:0] beats_left;
	logic [3:0] next_beats_left;
	logic [2:0] step;
	logic [2:0] next_step;
	logic [2:0] start;
	logic [2:0] next_start;
	logic bl8;
	logic [2:0] low;
	drca_beat_type next_beat;
	always_comb
	begin
		bl8 = (mode.burst_len == drca_bl8_code);
		next_beats_left = (beats_left == 4'h0) ? beats_left : beats_left - drca_one;
		next_step = step + 3'h1;
		next_start = start;
		next_beat = beat;
		next_beat.valid = 1'b0;
		// A new command replaces the running burst: the BL8 interrupt case
		if (lat_valid)
		begin
			next_beats_left = (bl8 ? drca_beats_bl8 : drca_beats_bl4) - drca_one;
			next_step = 3'h1;
			next_start = lat_data[2:0];
			next_beat.write = lat_data[drca_bank_w+drca_col_w];
			next_beat.bank = lat_data[drca_bank_w+drca_col_w-1:drca_col_w];
		end
		low = lat_valid ? lat_data[2:0] : start;
		if (!lat_valid)
		begin
			if (!mode.interleave)
				low = bl8 ? {start[2] ^ step[2], start[1:0] + step[1:0]} :
					{start[2], start[1:0] + step[1:0]};
			else
				low = bl8 ? start ^ step : {start[2], start[1:0] ^ step[1:0]};
		end
		if (lat_valid || beats_left != 4'h0)
		begin
			next_beat.valid = 1'b1;
			next_beat.col = lat_valid ? lat_data[drca_col_w-1:0] :
				{beat.col[drca_col_w-1:3], low};
		end
	end
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			beats_left <= 4'h0;
			step <= 3'h0;
			start <= 3'h0;
			beat <= '0;
		end
		else
		begin
			beats_left <= next_beats_left;
			step <= next_step;
			start <= next_start;
			beat <= next_beat;
		end
	end
endmodule
`default_nettype wire
